// ### logic/lsw_pkg.sv
// shared constants and types for the lane swing and termination control block
package lsw_pkg;

  // four-level pin codes as resolved by the pad comparators
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_DIV = 2'h1;
  localparam logic [1:0] LVL_FLOAT = 2'h2;
  localparam logic [1:0] LVL_HIGH = 2'h3;

  // lane index layout of the six receive lanes
  localparam int LANES = 6;
  localparam logic [5:0] LANES_ALL = 6'h3F;
  localparam logic [5:0] LANES_AUTO_B = 6'h3C;
  localparam logic [5:0] LANES_AUTO_A = 6'h33;

  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int POLL_TIME_MS = 12;
  localparam int POLL_CNT_W = 18;
  localparam logic [POLL_CNT_W-1:0] POLL_CYCLES = POLL_CNT_W'(POLL_TIME_MS * 1000000 / CLK_PERIOD_NS);
  localparam int SETTLE_TIME_NS = 1000;
  localparam int SETTLE_CNT_W = 5;
  localparam logic [SETTLE_CNT_W-1:0] SETTLE_CYCLES =
    SETTLE_CNT_W'((SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_SWING = 8'h08;

  // control fields and reset value
  localparam int CTRL_POLL_RUN_BIT = 0;
  localparam int CTRL_RESCAN_BIT = 1;
  localparam logic CTRL_POLL_RUN_RST = 1'b1;

  // status fields
  localparam int STAT_DET_LSB = 0;
  localparam int STAT_TERM_LSB = 8;
  localparam int STAT_MODE_LSB = 16;
  localparam int STAT_LOWPWR_BIT = 20;

  // swing register fields
  localparam int SWG_HOST_SET_LSB = 0;
  localparam int SWG_SWITCH_SET_LSB = 4;
  localparam int SWG_HOST_DEEMPH_LSB = 8;
  localparam int SWG_SWITCH_DEEMPH_LSB = 16;

  // swing in mV and de-emphasis in tenths of dB, by setting index {hi,lo}
  localparam logic [10:0] SWING_MV_TBL [16] = '{
    11'h258, 11'h320, 11'h320, 11'h384, 11'h384, 11'h384, 11'h3E8, 11'h3E8,
    11'h3E8, 11'h44C, 11'h44C, 11'h44C, 11'h4B0, 11'h4B0, 11'h4B0, 11'h4B0};
  localparam logic [6:0] DEEMPH_TBL [16] = '{
    7'h00, 7'h00, 7'h23, 7'h00, 7'h23, 7'h3C, 7'h00, 7'h23,
    7'h3C, 7'h00, 7'h23, 7'h3C, 7'h00, 7'h23, 7'h3C, 7'h5A};
  localparam logic [10:0] SWING_MAX_MV = 11'h4B0;
  localparam logic [6:0] DEEMPH_MAX = 7'h5A;

  typedef enum logic [2:0] {
    MODE_LOW_POWER,
    MODE_MANUAL_MUX,
    MODE_RESERVED,
    MODE_AUTO_B,
    MODE_AUTO_A,
    MODE_FANOUT
  } lsw_mode_t;

  typedef enum logic {
    ST_IDLE,
    ST_SETTLE
  } lsw_poll_st_t;

endpackage

// ### logic/lsw_swing_dec.sv
// swing and de-emphasis decode for one output side
`timescale 1ns/1ns
module lsw_swing_dec (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // synchronised level codes of the pin pair
  input wire logic [1:0] pin_hi,
  input wire logic [1:0] pin_lo,
  // decoded setting
  output logic [3:0] setting_q,
  output logic [10:0] swing_mv_q,
  output logic [6:0] deemph_q
);

  logic [3:0] idx;

  assign idx = {pin_hi, pin_lo};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      setting_q <= 4'h0;
      swing_mv_q <= lsw_pkg::SWING_MV_TBL[0];
      deemph_q <= lsw_pkg::DEEMPH_TBL[0];
    end else begin
      setting_q <= idx;
      swing_mv_q <= lsw_pkg::SWING_MV_TBL[idx];
      deemph_q <= lsw_pkg::DEEMPH_TBL[idx];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_TOP_SETTING: assert property ((pin_hi == lsw_pkg::LVL_HIGH && pin_lo == lsw_pkg::LVL_HIGH)
    |=> (swing_mv_q == lsw_pkg::SWING_MAX_MV && deemph_q == lsw_pkg::DEEMPH_MAX))
    else $error("top pin levels did not give largest swing and deemphasis");
  AST_LOW_HI_PIN: assert property ((pin_hi == lsw_pkg::LVL_LOW) |=> (swing_mv_q < 11'h385))
    else $error("low upper pin gave too large a swing");

endmodule // lsw_swing_dec

// ### logic/lsw_ctrl.sv
// pin-mode swing decode and input termination control with receiver-detect polling
//
// Behaviour
// - each side's pin pair decodes to one of sixteen swing and de-emphasis settings
// - host side and switch side take settings from their own pin pairs
// - reset pin high gives low power with every termination high impedance
// - path pin low gives manual mux with all terminations on
// - path pin high gives manual fanout with all terminations on
// - auto with select low or divider: side A high-Z, detect on B and host
// - auto with select float or high: side B high-Z, detect on A and host
// - auto mode probes undetected lanes every 12 ms until found
// - undetected auto lanes keep termination high impedance
// - a detected auto lane switches termination on
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ns
module lsw_ctrl #(
  parameter logic [lsw_pkg::POLL_CNT_W-1:0] POLL_CYCLES = lsw_pkg::POLL_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // strap pins, level codes from the pad comparators
  input wire logic powerdown_pin,
  input wire logic [1:0] path_mode_pin,
  input wire logic [1:0] source_pick_pin_first,
  input wire logic [1:0] source_pick_pin_second,
  input wire logic [1:0] host_side_swing_pin_hi,
  input wire logic [1:0] host_side_swing_pin_lo,
  input wire logic [1:0] switch_side_swing_pin_hi,
  input wire logic [1:0] switch_side_swing_pin_lo,
  // receiver detect, lanes a0 a1 b0 b1 host0 host1
  input wire logic [5:0] rx_present,
  output logic [5:0] probe_req_q,
  // termination and mode
  output logic [5:0] term_on_q,
  output logic low_power_q,
  output logic [2:0] mode_code,
  // host side output setting
  output logic [3:0] host_setting_q,
  output logic [10:0] host_output_swing_level_q,
  output logic [6:0] host_deemph_level_q,
  // switch side output setting
  output logic [3:0] switch_setting_q,
  output logic [10:0] switch_output_swing_level_q,
  output logic [6:0] switch_deemph_level_q,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_q
);

  localparam int PIN_W = 21;
  // the reset pin reads as asserted until the first real sample, so release never flashes terminations on
  localparam logic [PIN_W-1:0] PIN_RST = {1'b1, 20'h0_0000};
  localparam logic [lsw_pkg::POLL_CNT_W-1:0] POLL_LAST = POLL_CYCLES - 18'h1;
  localparam logic [lsw_pkg::SETTLE_CNT_W-1:0] SETTLE_LAST = lsw_pkg::SETTLE_CYCLES - 5'h1;

  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_meta_q;
  logic [PIN_W-1:0] pin_sync_q;
  logic pd_s;
  logic [1:0] path_s;
  logic [1:0] source_pick_pin_second_s;
  logic [1:0] sel2_s;
  logic [1:0] hs_hi_s;
  logic [1:0] hs_lo_s;
  logic [1:0] sw_hi_s;
  logic [1:0] sw_lo_s;
  logic [5:0] rx_s;
  lsw_pkg::lsw_mode_t mode_d;
  lsw_pkg::lsw_mode_t mode_q;
  logic mode_chg;
  logic is_auto;
  logic [5:0] auto_mask;
  logic poll_run_q;
  logic rescan_wr;
  logic restart;
  logic [lsw_pkg::POLL_CNT_W-1:0] poll_cnt_q;
  logic tick;
  logic [5:0] pending;
  lsw_pkg::lsw_poll_st_t st_q;
  logic [lsw_pkg::SETTLE_CNT_W-1:0] settle_cnt_q;
  logic [5:0] probed_q;
  logic sample;
  logic [5:0] det_q;
  logic [31:0] rd_val;

  // mode from reset pin, path pin and first select pin
  function automatic lsw_pkg::lsw_mode_t decode_mode(input logic pd, input logic [1:0] path,
                                                      input logic [1:0] sel);
    if (pd) begin
      decode_mode = lsw_pkg::MODE_LOW_POWER;
    end else begin
      case (path)
        lsw_pkg::LVL_LOW: decode_mode = lsw_pkg::MODE_MANUAL_MUX;
        lsw_pkg::LVL_DIV: decode_mode = lsw_pkg::MODE_RESERVED;
        lsw_pkg::LVL_HIGH: decode_mode = lsw_pkg::MODE_FANOUT;
        default: begin
          if (sel == lsw_pkg::LVL_LOW || sel == lsw_pkg::LVL_DIV) begin
            decode_mode = lsw_pkg::MODE_AUTO_B;
          end else begin
            decode_mode = lsw_pkg::MODE_AUTO_A;
          end
        end
      endcase
    end
  endfunction

  // lanes that run receiver detection in a mode
  function automatic logic [5:0] lane_mask(input lsw_pkg::lsw_mode_t m);
    case (m)
      lsw_pkg::MODE_AUTO_B: lane_mask = lsw_pkg::LANES_AUTO_B;
      lsw_pkg::MODE_AUTO_A: lane_mask = lsw_pkg::LANES_AUTO_A;
      default: lane_mask = 6'h00;
    endcase
  endfunction

  // every pin code passes two flops
  assign pin_raw = {powerdown_pin, path_mode_pin, source_pick_pin_first, source_pick_pin_second,
                    host_side_swing_pin_hi, host_side_swing_pin_lo, switch_side_swing_pin_hi,
                    switch_side_swing_pin_lo, rx_present};

  // a level code may show one mixed value while a strap moves; it settles a cycle later
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_meta_q <= PIN_RST;
      pin_sync_q <= PIN_RST;
    end else begin
      pin_meta_q <= pin_raw;
      pin_sync_q <= pin_meta_q;
    end
  end

  assign {pd_s, path_s, source_pick_pin_second_s, sel2_s, hs_hi_s, hs_lo_s, sw_hi_s, sw_lo_s, rx_s} = pin_sync_q;

  lsw_swing_dec u_host_dec (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_hi(hs_hi_s),
    .pin_lo(hs_lo_s),
    .setting_q(host_setting_q),
    .swing_mv_q(host_output_swing_level_q),
    .deemph_q(host_deemph_level_q)
  );

  lsw_swing_dec u_switch_dec (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_hi(sw_hi_s),
    .pin_lo(sw_lo_s),
    .setting_q(switch_setting_q),
    .swing_mv_q(switch_output_swing_level_q),
    .deemph_q(switch_deemph_level_q)
  );

  // divider level on the path pin lands in the reserved mode
  assign mode_d = decode_mode(pd_s, path_s, source_pick_pin_second_s);
  assign mode_chg = (mode_d != mode_q);
  assign is_auto = (mode_q == lsw_pkg::MODE_AUTO_A) || (mode_q == lsw_pkg::MODE_AUTO_B);
  assign auto_mask = lane_mask(mode_q);
  assign mode_code = mode_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_q <= lsw_pkg::MODE_LOW_POWER;
    end else begin
      mode_q <= mode_d;
    end
  end

  // register writes
  assign rescan_wr = reg_wr && reg_addr == lsw_pkg::REG_CTRL && reg_wdata[lsw_pkg::CTRL_RESCAN_BIT];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      poll_run_q <= lsw_pkg::CTRL_POLL_RUN_RST;
    end else if (reg_wr && reg_addr == lsw_pkg::REG_CTRL) begin
      poll_run_q <= reg_wdata[lsw_pkg::CTRL_POLL_RUN_BIT];
    end
  end

  // timer restarts on any mode change
  assign restart = mode_chg || rescan_wr;

  always_ff @(posedge clk) begin
    if (sys_rst || restart || !is_auto || !poll_run_q || poll_cnt_q == POLL_LAST) begin
      poll_cnt_q <= '0;
    end else begin
      poll_cnt_q <= poll_cnt_q + 18'h1;
    end
  end

  assign tick = is_auto && poll_run_q && !restart && poll_cnt_q == POLL_LAST;
  assign pending = auto_mask & ~det_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      probe_req_q <= 6'h00;
    end else begin
      probe_req_q <= tick ? pending : 6'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || restart) begin
      st_q <= lsw_pkg::ST_IDLE;
      settle_cnt_q <= '0;
      probed_q <= 6'h00;
    end else begin
      case (st_q)
        lsw_pkg::ST_IDLE: begin
          settle_cnt_q <= '0;
          if (tick && pending != 6'h00) begin
            probed_q <= pending;
            st_q <= lsw_pkg::ST_SETTLE;
          end
        end
        lsw_pkg::ST_SETTLE: begin
          settle_cnt_q <= settle_cnt_q + 5'h1;
          if (settle_cnt_q == SETTLE_LAST) begin
            st_q <= lsw_pkg::ST_IDLE;
          end
        end
        default: st_q <= lsw_pkg::ST_IDLE;
      endcase
    end
  end

  assign sample = st_q == lsw_pkg::ST_SETTLE && settle_cnt_q == SETTLE_LAST;

  // mode change clears detection; a sample beats a software rescan
  always_ff @(posedge clk) begin
    if (sys_rst || mode_chg) begin
      det_q <= 6'h00;
    end else begin
      det_q <= (rescan_wr ? 6'h00 : det_q) | (sample ? (probed_q & rx_s) : 6'h00);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      term_on_q <= 6'h00;
      low_power_q <= 1'b1;
    end else begin
      low_power_q <= mode_q == lsw_pkg::MODE_LOW_POWER;
      case (mode_q)
        lsw_pkg::MODE_MANUAL_MUX: term_on_q <= lsw_pkg::LANES_ALL;
        lsw_pkg::MODE_FANOUT: term_on_q <= lsw_pkg::LANES_ALL;
        lsw_pkg::MODE_AUTO_A: term_on_q <= det_q & auto_mask;
        lsw_pkg::MODE_AUTO_B: term_on_q <= det_q & auto_mask;
        default: term_on_q <= 6'h00;
      endcase
    end
  end

  // register reads, data valid only in the cycle after the strobe
  always_comb begin
    rd_val = 32'h0000_0000;
    case (reg_addr)
      lsw_pkg::REG_CTRL: rd_val[lsw_pkg::CTRL_POLL_RUN_BIT] = poll_run_q;
      lsw_pkg::REG_STATUS: begin
        rd_val[lsw_pkg::STAT_DET_LSB +: 6] = det_q;
        rd_val[lsw_pkg::STAT_TERM_LSB +: 6] = term_on_q;
        rd_val[lsw_pkg::STAT_MODE_LSB +: 3] = mode_q;
        rd_val[lsw_pkg::STAT_LOWPWR_BIT] = low_power_q;
      end
      lsw_pkg::REG_SWING: begin
        rd_val[lsw_pkg::SWG_HOST_SET_LSB +: 4] = host_setting_q;
        rd_val[lsw_pkg::SWG_SWITCH_SET_LSB +: 4] = switch_setting_q;
        rd_val[lsw_pkg::SWG_HOST_DEEMPH_LSB +: 7] = host_deemph_level_q;
        rd_val[lsw_pkg::SWG_SWITCH_DEEMPH_LSB +: 7] = switch_deemph_level_q;
      end
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata_q <= 32'h0000_0000;
    end else begin
      reg_rdata_q <= reg_rd ? rd_val : 32'h0000_0000;
    end
  end

  // checking helpers: cycles since last poll tick
  logic [lsw_pkg::POLL_CNT_W-1:0] gap_cnt_q;
  logic gap_vld_q;

  always_ff @(posedge clk) begin
    if (sys_rst || restart || !is_auto || !poll_run_q) begin
      gap_cnt_q <= '0;
      gap_vld_q <= 1'b0;
    end else if (tick) begin
      gap_cnt_q <= '0;
      gap_vld_q <= 1'b1;
    end else begin
      gap_cnt_q <= gap_cnt_q + 18'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_PD_LOW_POWER: assert property (pd_s ##1 pd_s |=> (low_power_q && term_on_q == 6'h00))
    else $error("reset pin high did not give low power with high-Z inputs");
  AST_MUX_TERM: assert property (mode_q == lsw_pkg::MODE_MANUAL_MUX |=> term_on_q == lsw_pkg::LANES_ALL)
    else $error("manual mux mode without full termination");
  AST_FANOUT_TERM: assert property ((path_s == lsw_pkg::LVL_HIGH && !pd_s) ##1 (mode_q == lsw_pkg::MODE_FANOUT)
    |=> term_on_q == lsw_pkg::LANES_ALL)
    else $error("fanout mode without full termination");
  AST_AUTO_B_SIDE_A: assert property (mode_q == lsw_pkg::MODE_AUTO_B |=> term_on_q[1:0] == 2'h0)
    else $error("side A terminated in auto mode on side B");
  AST_AUTO_A_SIDE_B: assert property (mode_q == lsw_pkg::MODE_AUTO_A |=> term_on_q[3:2] == 2'h0)
    else $error("side B terminated in auto mode on side A");
  AST_POLL_PERIOD: assert property (tick && gap_vld_q |-> gap_cnt_q == POLL_LAST)
    else $error("poll interval differs from the poll period");
  AST_PROBE_PENDING: assert property (probe_req_q != 6'h00 |-> (probe_req_q & det_q) == 6'h00
    && $past(tick))
    else $error("probe on a detected lane or off the poll tick");
  AST_UNDET_HIZ: assert property (is_auto |=> (term_on_q & ~$past(det_q)) == 6'h00)
    else $error("undetected lane terminated");
  AST_DET_TERM: assert property (is_auto && !mode_chg |=> term_on_q == $past(det_q & auto_mask))
    else $error("detected lane not terminated");
  AST_CHG_CLEAR: assert property ($changed(mode_q) |-> (det_q == 6'h00 && poll_cnt_q == '0))
    else $error("mode change left detection or timer running");
  AST_HOST_OWN_PINS: assert property (##1 host_setting_q == $past({hs_hi_s, hs_lo_s})
    && switch_setting_q == $past({sw_hi_s, sw_lo_s}))
    else $error("side settings not taken from own pins");

  COV_DETECT: cover property (is_auto ##1 $rose(term_on_q[4]));
  COV_FANOUT: cover property (mode_q == lsw_pkg::MODE_FANOUT);
  COV_LOW_POWER: cover property ($rose(low_power_q));
  COV_PROBE: cover property (probe_req_q != 6'h00);

endmodule // lsw_ctrl

// ### dv/lsw_rx_model.sv
// far-side receivers answering receiver-detect probes on the six lanes
`timescale 1ns/1ns
module lsw_rx_model (
  // clock
  input wire logic clk,
  // probe requests from the block and board population
  input wire logic [5:0] probe_req_q,
  input wire logic [5:0] attached,
  // detect result seen by the block
  output logic [5:0] rx_present
);
  int win_q [6];
  logic [5:0] noise_q = 6'h00;
  // result only meaningful inside the probe window; outside it the line keeps changing
  always @(posedge clk) begin
    noise_q <= ~noise_q;
    for (int i = 0; i < 6; i++) begin
      if (probe_req_q[i] === 1'b1) begin
        win_q[i] <= 40;
      end else if (win_q[i] > 0) begin
        win_q[i] <= win_q[i] - 1;
      end
    end
  end
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      rx_present[i] = (win_q[i] > 0) ? attached[i] : noise_q[i];
    end
  end
endmodule // lsw_rx_model

// ### dv/lsw_ctrl_tb.sv
// self-checking testbench of the swing and termination control block
`timescale 1ns/1ns
module lsw_ctrl_tb;
  localparam int POLL = 64;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic powerdown_pin = 1'b1;
  logic [1:0] path_mode_pin = 2'h2;
  logic [1:0] sel_first = 2'h0;
  logic [1:0] sel_second = 2'h0;
  logic [1:0] host_hi = 2'h0;
  logic [1:0] host_lo = 2'h0;
  logic [1:0] sw_hi = 2'h0;
  logic [1:0] sw_lo = 2'h0;
  logic [5:0] attached = 6'h00;
  logic [5:0] rx_present;
  logic [5:0] probe_req_q;
  logic [5:0] term_on_q;
  logic low_power_q;
  logic [2:0] mode_code;
  logic [3:0] host_setting_q;
  logic [10:0] host_swing;
  logic [6:0] host_deemph;
  logic [3:0] switch_setting_q;
  logic [10:0] sw_swing;
  logic [6:0] sw_deemph;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata_q;
  logic rd_seen = 1'b0;
  logic [31:0] exp_q [$];
  logic [31:0] seed = 32'hE5B3FF37;
  logic [5:0] lanes;
  int errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int t0;
  int swing_mv [16] = '{600, 800, 800, 900, 900, 900, 1000, 1000, 1000, 1100, 1100, 1100, 1200, 1200, 1200, 1200};
  int deemph_t [16] = '{0, 0, 35, 0, 35, 60, 0, 35, 60, 0, 35, 60, 0, 35, 60, 90};

  always #25 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  lsw_ctrl #(.POLL_CYCLES(18'(POLL))) uut (
    .clk(clk), .sys_rst(sys_rst), .powerdown_pin(powerdown_pin), .path_mode_pin(path_mode_pin),
    .source_pick_pin_first(sel_first), .source_pick_pin_second(sel_second),
    .host_side_swing_pin_hi(host_hi), .host_side_swing_pin_lo(host_lo),
    .switch_side_swing_pin_hi(sw_hi), .switch_side_swing_pin_lo(sw_lo),
    .rx_present(rx_present), .probe_req_q(probe_req_q), .term_on_q(term_on_q),
    .low_power_q(low_power_q), .mode_code(mode_code), .host_setting_q(host_setting_q),
    .host_output_swing_level_q(host_swing), .host_deemph_level_q(host_deemph),
    .switch_setting_q(switch_setting_q), .switch_output_swing_level_q(sw_swing),
    .switch_deemph_level_q(sw_deemph), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));

  lsw_rx_model partner (.clk(clk), .probe_req_q(probe_req_q), .attached(attached), .rx_present(rx_present));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction

  function automatic logic [31:0] stat(input logic [5:0] det, input logic [5:0] term,
                                       input logic [2:0] mode, input logic lp);
    return {11'h000, lp, 1'b0, mode, 2'h0, term, 2'h0, det};
  endfunction

  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t mismatch got %h expected %h", $time, got, exp);
    end
  endtask

  // read data stand only in the cycle after the strobe, so compare at that cycle's falling edge
  always @(posedge clk) rd_seen <= reg_rd;
  always @(negedge clk) begin
    if (rd_seen === 1'b1) begin
      chk(reg_rdata_q, exp_q.pop_front());
    end
  end

  task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(exp);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic set_straps(input logic pd, input logic [1:0] path, input logic [1:0] sel);
    @(posedge clk);
    powerdown_pin <= pd;
    path_mode_pin <= path;
    sel_first <= sel;
    sel_second <= sel;
    repeat (6) @(posedge clk);
    #1;
  endtask

  task automatic wait_probe(input int maxc);
    lanes = 6'h00;
    for (int i = 0; i < maxc && lanes == 6'h00; i++) begin
      @(posedge clk);
      #1;
      if (probe_req_q !== 6'h00) lanes = probe_req_q;
    end
    if (lanes == 6'h00) begin
      errors++;
      $display("[ERR] %0t no probe seen", $time);
      print_verdict();
    end
  endtask

  task automatic no_probe(input int n);
    int seen;
    seen = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (probe_req_q !== 6'h00) seen++;
    end
    chk(32'(seen), 32'h0);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    // the reset pin is high throughout, so none of the first six edges after release may show a termination
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      #1;
      chk({31'h0, low_power_q}, 32'h1);
      chk({26'h0, term_on_q}, 32'h0);
    end
    reg_read(8'h04, stat(6'h00, 6'h00, 3'h0, 1'b1));
    reg_read(8'h00, 32'h1);
    reg_write(8'h0C, 32'hFFFFFFFF);
    reg_write(8'h04, 32'hFFFFFFFF);
    reg_read(8'h0C, 32'h0);
    reg_read(8'h04, stat(6'h00, 6'h00, 3'h0, 1'b1));
    // each level code pair, switch side driven from unrelated random codes
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      @(posedge clk);
      {host_hi, host_lo} <= 4'(i);
      {sw_hi, sw_lo} <= seed[3:0];
      repeat (4) @(posedge clk);
      #1;
      chk({28'h0, host_setting_q}, 32'(i));
      chk({21'h0, host_swing}, 32'(swing_mv[i]));
      chk({25'h0, host_deemph}, 32'(deemph_t[i]));
      chk({21'h0, sw_swing}, 32'(swing_mv[seed[3:0]]));
      chk({25'h0, sw_deemph}, 32'(deemph_t[seed[3:0]]));
      chk({28'h0, switch_setting_q}, {28'h0, seed[3:0]});
      reg_read(8'h08, {9'h0, 7'(deemph_t[seed[3:0]]), 1'b0, 7'(deemph_t[i]), seed[3:0], 4'(i)});
    end
    set_straps(1'b0, 2'h0, seed[1:0]);
    reg_read(8'h04, stat(6'h00, 6'h3F, 3'h1, 1'b0));
    set_straps(1'b0, 2'h3, seed[3:2]);
    reg_read(8'h04, stat(6'h00, 6'h3F, 3'h5, 1'b0));
    // divider level on the path pin only while the reset pin holds the part in low power
    set_straps(1'b1, 2'h1, seed[5:4]);
    reg_read(8'h04, stat(6'h00, 6'h00, 3'h0, 1'b1));
    seed = lfsr(seed);
    set_straps(1'b0, 2'h2, {1'b0, seed[0]});
    chk({29'h0, mode_code}, 32'(lsw_pkg::MODE_AUTO_B));
    reg_read(8'h04, stat(6'h00, 6'h00, 3'h3, 1'b0));
    wait_probe(2 * POLL);
    chk({26'h0, lanes}, 32'h3C);
    t0 = cyc;
    wait_probe(2 * POLL);
    chk(32'(cyc - t0), 32'(POLL));
    attached = 6'h0C;
    wait_probe(2 * POLL);
    repeat (30) @(posedge clk);
    reg_read(8'h04, stat(6'h0C, 6'h0C, 3'h3, 1'b0));
    attached = 6'h3F;
    wait_probe(2 * POLL);
    chk({26'h0, lanes}, 32'h30);
    repeat (30) @(posedge clk);
    reg_read(8'h04, stat(6'h3C, 6'h3C, 3'h3, 1'b0));
    no_probe(2 * POLL);
    set_straps(1'b0, 2'h2, {1'b1, seed[1]});
    reg_read(8'h04, stat(6'h00, 6'h00, 3'h4, 1'b0));
    wait_probe(2 * POLL);
    chk({26'h0, lanes}, 32'h33);
    repeat (30) @(posedge clk);
    reg_read(8'h04, stat(6'h33, 6'h33, 3'h4, 1'b0));
    // rescan with the timer frozen: detection cleared and nothing probed
    reg_write(8'h00, 32'h2);
    reg_read(8'h04, stat(6'h00, 6'h00, 3'h4, 1'b0));
    no_probe(2 * POLL);
    reg_read(8'h00, 32'h0);
    reg_write(8'h00, 32'h1);
    wait_probe(3 * POLL);
    chk({26'h0, lanes}, 32'h33);
    repeat (30) @(posedge clk);
    set_straps(1'b1, 2'h2, {1'b1, seed[1]});
    reg_read(8'h04, stat(6'h00, 6'h00, 3'h0, 1'b1));
    set_straps(1'b0, 2'h2, {1'b1, seed[1]});
    reg_read(8'h04, stat(6'h00, 6'h00, 3'h4, 1'b0));
    wait_probe(2 * POLL);
    chk({26'h0, lanes}, 32'h33);
    repeat (4) @(posedge clk);
    print_verdict();
  end
endmodule // lsw_ctrl_tb
